// *** rtl/lmac_pkg.sv ***
// Constants, types and helpers for the LED matrix mode and audio control core
// Notes on behaviour
// - Breathing only when enabled, picture/auto modes
// - Dark interval is 3.5 ms times 2^field
// - Shutdown bit 0 shuts down, resets 0
// - Gain control enable bit 3, speed bit 4
// - Audio gain 3 dB steps, audio modes and audio sync
// - Sample interval 46 us times value, 0=256
// - PWM value selects one of 256 steps
// - Mode 00 shows selected static picture frame
// - Mode 01 auto plays frames from start frame fs
// - Auto play loops and frame count register
// - Auto play delay and fades from registers
// - Mode 1x picks frame from audio level
// - Audio sync scales intensity by gained input
// - Blink enabled LEDs marked in blink bits
// - Blink period set, 50 percent duty
// - Shutdown blanks matrix, registers keep contents
package lmac_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CONFIG      = 8'h00;
  localparam logic [7:0] REG_PICTURE     = 8'h01;
  localparam logic [7:0] REG_AUTOPLAY1   = 8'h02;
  localparam logic [7:0] REG_AUTOPLAY2   = 8'h03;
  localparam logic [7:0] REG_DISP_OPT    = 8'h05;
  localparam logic [7:0] REG_AUDIO_SYNC  = 8'h06;
  localparam logic [7:0] REG_FRAME_STATE = 8'h07;
  localparam logic [7:0] REG_BREATH1     = 8'h08;
  localparam logic [7:0] REG_BREATH2     = 8'h09;
  localparam logic [7:0] REG_SHUTDOWN    = 8'h0A;
  localparam logic [7:0] REG_GAIN        = 8'h0B;
  localparam logic [7:0] REG_SAMPLE_RATE = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions, masks, reset values
  // ----------------------------------------------------------------
  localparam int CFG_MODE_LSB   = 3;
  localparam int CFG_FS_LSB     = 0;
  localparam int PIC_PFS_LSB    = 0;
  localparam int AP1_LOOP_LSB   = 4;
  localparam int AP1_FRM_LSB    = 0;
  localparam int AP2_DLY_LSB    = 0;
  localparam int DOPT_BE_BIT    = 3;
  localparam int DOPT_BPT_LSB   = 0;
  localparam int AS_AE_BIT      = 0;
  localparam int BR1_OUT_LSB    = 4;
  localparam int BR1_IN_LSB     = 0;
  localparam int BR2_EN_BIT     = 4;
  localparam int BR2_ET_LSB     = 0;
  localparam int SD_BIT         = 0;
  localparam int GN_SPEED_BIT   = 4;
  localparam int GN_AGC_BIT     = 3;
  localparam int GN_GS_LSB      = 0;
  localparam logic [7:0] SD_MASK   = 8'h01;
  localparam logic [7:0] GAIN_MASK = 8'h1F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] LEVEL_MAX = 8'hFF;

  // ----------------------------------------------------------------
  // Modes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_PICTURE = 2'h0;
  localparam logic [1:0] MODE_AUTO    = 2'h1;
  localparam int  CLK_MHZ          = 100;
  localparam real BREATH_UNIT_MS   = 3.5;
  localparam real SAMPLE_UNIT_US   = 46.0;
  localparam real FRAME_UNIT_MS    = 11.0;
  localparam real BLINK_UNIT_MS    = 27.0;
  localparam real SCAN_FRAME_US    = 10.0;
  localparam int BREATH_UNIT_CYC = int'(BREATH_UNIT_MS * 1000.0 * CLK_MHZ);
  localparam int SAMPLE_UNIT_CYC = int'(SAMPLE_UNIT_US * CLK_MHZ);
  localparam int FRAME_UNIT_CYC  = int'(FRAME_UNIT_MS * 1000.0 * CLK_MHZ);
  localparam int BLINK_UNIT_CYC  = int'(BLINK_UNIT_MS * 1000.0 * CLK_MHZ);
  localparam int SCAN_FRAME_CYC  = int'(SCAN_FRAME_US * CLK_MHZ);
  localparam int DELAY_ZERO_UNITS = 64;
  localparam int RATE_ZERO_UNITS  = 256;

  typedef enum logic [4:0] {
    ST_SHOW     = 5'b00001,
    ST_FADE_OUT = 5'b00010,
    ST_DARK     = 5'b00100,
    ST_FADE_IN  = 5'b01000,
    ST_DONE     = 5'b10000
  } lmac_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lmac_reg_req_t;

  typedef struct packed {
    logic [2:0] frame;
    logic       blank;
    logic       blink_phase;
    logic [7:0] breath;
  } lmac_disp_t;

  // Gain in 3 dB steps, multiplier in 1/16 units, saturating
  function automatic logic [7:0] lmac_gain(input logic [7:0] lvl,
                                           input logic [2:0] code);
    logic [7:0]  mult;
    logic [15:0] prod;
    mult = 8'h10;
    unique case (code)
      3'h0: mult = 8'h10;
      3'h1: mult = 8'h17;
      3'h2: mult = 8'h20;
      3'h3: mult = 8'h2D;
      3'h4: mult = 8'h40;
      3'h5: mult = 8'h5B;
      3'h6: mult = 8'h80;
      3'h7: mult = 8'hB5;
    endcase
    prod = (lvl * mult) >> 4;
    lmac_gain = (prod > 16'h00FF) ? 8'hFF : prod[7:0];
  endfunction : lmac_gain

endpackage : lmac_pkg

// *** rtl/lmac_core.sv ***
// Mode, breathing, blink, shutdown and audio control core
`timescale 1ns/1ps
module lmac_core
  import lmac_pkg::*;
#(
  parameter int BREATH_CYC = BREATH_UNIT_CYC,
  parameter int SAMPLE_CYC = SAMPLE_UNIT_CYC,
  parameter int FRAME_CYC  = FRAME_UNIT_CYC,
  parameter int BLINK_CYC  = BLINK_UNIT_CYC,
  parameter int SCAN_CYC   = SCAN_FRAME_CYC
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rstn,
  // Register port
  input  wire lmac_reg_req_t reg_req,
  output logic [7:0]         reg_rdata,
  // Audio level and current pixel
  input  wire logic [7:0]    audio_level,
  input  wire logic [7:0]    pix_pwm,
  input  wire logic          pix_blink,
  // Display and analog control
  output logic [7:0]         pix_duty,
  output lmac_disp_t         disp,
  output logic               agc_enable,
  output logic               agc_fast,
  output logic [2:0]         gain_code,
  output logic               gain_active,
  output logic               sample_strobe
);

  // ----------------------------------------------------------------
  // Checks and helpers
  // ----------------------------------------------------------------
  // Fade needs at least one cycle per level step
  if (BREATH_CYC < 256 || SAMPLE_CYC < 1 || FRAME_CYC < 1 ||
      BLINK_CYC < 1 || SCAN_CYC < 1)
    $error("lmac_core: unit counts out of range");

  function automatic logic [7:0] scale8(input logic [7:0] x,
                                        input logic [7:0] s);
    logic [16:0] p;
    p = x * ({1'b0, s} + 9'h001);
    scale8 = p[15:8];
  endfunction : scale8

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1, rst_n;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] cfg, pic, ap1, ap2, dopt, async_r, br1, br2, sd, gain, srate;
  logic [7:0] next_cfg, next_pic, next_ap1, next_ap2, next_dopt;
  logic [7:0] next_async, next_br1, next_br2, next_sd, next_gain;
  logic [7:0] next_srate, next_rdata;
  logic [2:0] frame;

  always_comb
  begin
    {next_cfg, next_pic, next_ap1, next_ap2, next_dopt, next_async} =
        {cfg, pic, ap1, ap2, dopt, async_r};
    {next_br1, next_br2, next_sd, next_gain, next_srate, next_rdata} =
        {br1, br2, sd, gain, srate, reg_rdata};
    if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        REG_CONFIG:      next_cfg   = reg_req.wdata;
        REG_PICTURE:     next_pic   = reg_req.wdata;
        REG_AUTOPLAY1:   next_ap1   = reg_req.wdata;
        REG_AUTOPLAY2:   next_ap2   = reg_req.wdata;
        REG_DISP_OPT:    next_dopt  = reg_req.wdata;
        REG_AUDIO_SYNC:  next_async = reg_req.wdata;
        REG_BREATH1:     next_br1   = reg_req.wdata;
        REG_BREATH2:     next_br2   = reg_req.wdata;
        REG_SHUTDOWN:    next_sd    = reg_req.wdata & SD_MASK;
        REG_GAIN:        next_gain  = reg_req.wdata & GAIN_MASK;
        REG_SAMPLE_RATE: next_srate = reg_req.wdata;
        default:         next_cfg   = cfg;
      endcase
    end
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        REG_CONFIG:      next_rdata = cfg;
        REG_PICTURE:     next_rdata = pic;
        REG_AUTOPLAY1:   next_rdata = ap1;
        REG_AUTOPLAY2:   next_rdata = ap2;
        REG_DISP_OPT:    next_rdata = dopt;
        REG_AUDIO_SYNC:  next_rdata = async_r;
        REG_FRAME_STATE: next_rdata = {5'h00, frame};
        REG_BREATH1:     next_rdata = br1;
        REG_BREATH2:     next_rdata = br2;
        REG_SHUTDOWN:    next_rdata = sd;
        REG_GAIN:        next_rdata = gain;
        REG_SAMPLE_RATE: next_rdata = srate;
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  // Registers keep contents through shutdown
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {cfg, pic, ap1, ap2, dopt, async_r} <= {6{REG_RESET}};
      {br1, br2, sd, gain, srate, reg_rdata} <= {6{REG_RESET}};
    end
    else
    begin
      {cfg, pic, ap1, ap2, dopt, async_r} <=
        {next_cfg, next_pic, next_ap1, next_ap2, next_dopt, next_async};
      {br1, br2, sd, gain, srate, reg_rdata} <=
        {next_br1, next_br2, next_sd, next_gain, next_srate, next_rdata};
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  logic [1:0] mode, cfg_mode;
  logic [2:0] fs, frames_n, gs;
  logic [1:0] loops;
  logic [3:0] n_frames;
  logic       breath_on, audio_mode, ae, be;
  assign cfg_mode   = cfg[CFG_MODE_LSB +: 2];
  assign fs         = cfg[CFG_FS_LSB +: 3];
  assign loops      = ap1[AP1_LOOP_LSB +: 2];
  assign frames_n   = ap1[AP1_FRM_LSB +: 3];
  assign n_frames   = (frames_n == 3'h0) ? 4'h8 : {1'b0, frames_n};
  assign gs         = gain[GN_GS_LSB +: 3];
  assign ae         = async_r[AS_AE_BIT];
  assign be         = dopt[DOPT_BE_BIT];
  assign audio_mode = mode[1];
  assign breath_on  = br2[BR2_EN_BIT] && !audio_mode;
  assign agc_enable = gain[GN_AGC_BIT];
  assign agc_fast   = gain[GN_SPEED_BIT];
  assign gain_code  = gs;
  assign gain_active = audio_mode || ae;

  // ----------------------------------------------------------------
  // Frame sequencing and breathing
  // ----------------------------------------------------------------
  lmac_state_t st, next_st;
  logic [31:0] cnt, next_cnt, scan_cnt, next_scan, hold_t, step_t, dark_t;
  logic [7:0]  level, next_level, aud_q, next_aud_q;
  logic [2:0]  next_frame, shown, next_shown;
  logic [1:0]  loopc, next_loopc, next_mode;
  logic        scan_tick, adv, frame_bnd, last, samp_fire;

  assign scan_tick = (scan_cnt == 32'(SCAN_CYC - 1));
  assign last = (loops != 2'h0) && (loopc == loops - 2'h1) &&
                ({1'b0, shown} == n_frames - 4'h1);
  assign hold_t = (mode == MODE_AUTO) ?
      32'(FRAME_CYC) * ((ap2[AP2_DLY_LSB +: 6] == 6'h00) ?
      32'(DELAY_ZERO_UNITS) : {26'h0, ap2[AP2_DLY_LSB +: 6]}) :
      32'(BREATH_CYC);
  assign step_t = (32'(BREATH_CYC) >> 8) << ((st == ST_FADE_OUT) ?
      br1[BR1_OUT_LSB +: 3] : br1[BR1_IN_LSB +: 3]);
  assign dark_t = 32'(BREATH_CYC) << br2[BR2_ET_LSB +: 3];

  always_comb
  begin
    next_st    = st;
    next_cnt   = cnt + 32'h1;
    {next_level, next_shown, next_loopc, next_frame, next_aud_q} =
        {level, shown, loopc, frame, aud_q};
    adv        = 1'b0;
    next_scan  = scan_tick ? 32'h0 : scan_cnt + 32'h1;
    unique case (st)
      ST_SHOW:
        if (mode != MODE_PICTURE || breath_on)
        begin
          if (cnt >= hold_t - 32'h1)
          begin
            next_cnt = 32'h0;
            if (mode == MODE_AUTO && last)
              next_st = ST_DONE;
            else if (breath_on)
              next_st = ST_FADE_OUT;
            else
              adv = (mode == MODE_AUTO);
          end
        end
        else
          next_cnt = 32'h0;
      ST_FADE_OUT:
        if (cnt >= step_t - 32'h1)
        begin
          next_cnt = 32'h0;
          next_level = level - 8'h01;
          if (level == 8'h01)
            next_st = ST_DARK;
        end
      ST_DARK:
        if (cnt >= dark_t - 32'h1)
        begin
          next_cnt = 32'h0;
          next_st  = ST_FADE_IN;
          adv      = (mode == MODE_AUTO);
        end
      ST_FADE_IN:
        if (cnt >= step_t - 32'h1)
        begin
          next_cnt = 32'h0;
          next_level = level + 8'h01;
          if (level == 8'hFE)
            next_st = ST_SHOW;
        end
      ST_DONE:
        next_cnt = 32'h0;
      default:
        next_st = ST_SHOW;
    endcase
    frame_bnd = (mode == MODE_AUTO && st != ST_DONE) ? adv : scan_tick;
    if (adv)
    begin
      next_shown = shown + 3'h1;
      if ({1'b0, shown} == n_frames - 4'h1)
      begin
        next_shown = 3'h0;
        next_loopc = loopc + 2'h1;
      end
    end
    if (!breath_on)
      next_level = LEVEL_MAX;
    if (samp_fire)
      next_aud_q = lmac_gain(audio_level, gs);
    next_mode = frame_bnd ? cfg_mode : mode;
    if (next_mode != mode)
    begin
      next_st    = ST_SHOW;
      next_cnt   = 32'h0;
      next_level = LEVEL_MAX;
      next_shown = 3'h0;
      next_loopc = 2'h0;
    end
    if (next_mode[1])
      next_frame = next_aud_q[7:5];
    else if (next_mode == MODE_AUTO)
      next_frame = fs + next_shown;
    else
      next_frame = pic[PIC_PFS_LSB +: 3];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st       <= ST_SHOW;
      {cnt, scan_cnt, level, shown} <= {64'h0, LEVEL_MAX, 3'h0};
      {loopc, frame, mode, aud_q} <= {2'h0, 3'h0, MODE_PICTURE, 8'h00};
    end
    else
    begin
      st       <= next_st;
      {cnt, scan_cnt, level, shown} <= {next_cnt, next_scan, next_level,
                                        next_shown};
      {loopc, frame, mode, aud_q} <= {next_loopc, next_frame, next_mode,
                                      next_aud_q};
    end
  end

  // ----------------------------------------------------------------
  // Audio sampling, blink, pixel output
  // ----------------------------------------------------------------
  // Sample counter idles outside audio play to keep phase fresh
  logic [31:0] samp_cnt, next_samp, samp_t, blink_cnt, next_blink, half_t;
  logic [7:0]  aud_scale, next_scale, next_duty;
  logic        blink_ph, next_blink_ph;
  assign samp_t = 32'(SAMPLE_CYC) * ((srate == 8'h00) ?
      32'(RATE_ZERO_UNITS) : {24'h0, srate});
  assign samp_fire = audio_mode && (samp_cnt >= samp_t - 32'h1);
  assign half_t = 32'(BLINK_CYC) << dopt[DOPT_BPT_LSB +: 3];

  always_comb
  begin
    next_samp = (!audio_mode || samp_fire) ? 32'h0 : samp_cnt + 32'h1;
    next_blink = blink_cnt + 32'h1;
    next_blink_ph = blink_ph;
    if (blink_cnt >= half_t - 32'h1)
    begin
      next_blink    = 32'h0;
      next_blink_ph = !blink_ph;
    end
    next_scale = ae ? lmac_gain(audio_level, gs) : LEVEL_MAX;
    next_duty  = scale8(scale8(pix_pwm, level), aud_scale);
    if (be && pix_blink && !blink_ph)
      next_duty = 8'h00;
    if (!sd[SD_BIT])
      next_duty = 8'h00;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {samp_cnt, blink_cnt, blink_ph} <= {64'h0, 1'b1};
      {aud_scale, pix_duty, sample_strobe} <= {LEVEL_MAX, 8'h00, 1'b0};
    end
    else
    begin
      {samp_cnt, blink_cnt, blink_ph} <= {next_samp, next_blink, next_blink_ph};
      {aud_scale, pix_duty, sample_strobe} <= {next_scale, next_duty, samp_fire};
    end
  end

  assign disp = '{frame: frame, blank: !sd[SD_BIT], blink_phase: blink_ph,
                  breath: level};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_shutdown_blank: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sd[SD_BIT] |=> pix_duty == 8'h00)
    else $error("duty not blank in shutdown");
  chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_req.wr && reg_req.addr == REG_GAIN |=> gain[7:5] == 3'h0 &&
    gain[4:0] == $past(reg_req.wdata[4:0]))
    else $error("gain write stored reserved bits");
  chk_agc_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_req.wr && reg_req.addr == REG_GAIN |=>
    agc_enable == $past(reg_req.wdata[3]) &&
    agc_fast == $past(reg_req.wdata[4]))
    else $error("gain control bits wrong");
  chk_breath_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !breath_on |=> level == LEVEL_MAX)
    else $error("breath level moved while disabled");
  chk_audio_frame: assert property (@(posedge core_clk) disable iff (!rst_n)
    samp_fire && cfg_mode[1] && !frame_bnd |=>
    frame == lmac_gain($past(audio_level), $past(gs)) >> 5)
    else $error("audio frame not from level");
  chk_pwm_direct: assert property (@(posedge core_clk) disable iff (!rst_n)
    sd[SD_BIT] && !be && level == LEVEL_MAX && aud_scale == LEVEL_MAX
    |=> pix_duty == $past(pix_pwm))
    else $error("duty does not follow pwm");
  chk_blink_half: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(blink_ph) |-> $past(blink_cnt) >= $past(half_t) - 32'h1)
    else $error("blink toggled early");
  chk_mode_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(mode) |-> $past(frame_bnd))
    else $error("mode changed off a frame boundary");
  chk_dark_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(st) == ST_DARK && st == ST_FADE_IN |->
    $past(cnt) == $past(dark_t) - 32'h1)
    else $error("dark interval length wrong");
  chk_sample_rate: assert property (@(posedge core_clk) disable iff (!rst_n)
    samp_fire && $past(audio_mode) && $stable(srate) |->
    samp_cnt == samp_t - 32'h1)
    else $error("sample interval wrong");

endmodule : lmac_core

// *** bench/lmac_host.sv ***
// Host controller model: register requests and soft brightness ramps
`timescale 1ns/1ps
module lmac_host
  import lmac_pkg::*;
(
  // Clock
  input  wire logic     core_clk,
  // Requests and pixel drive
  output lmac_reg_req_t req,
  output logic [7:0]    pwm
);
  // ------------------------------------------------------------
  // Gamma ramp, 32 entries suit a one second breath
  // ------------------------------------------------------------
  logic [7:0] gam [32] = '{0, 1, 2, 4, 6, 10, 13, 18, 22, 28, 33, 39, 46,
    53, 61, 69, 78, 86, 96, 106, 116, 126, 138, 149, 161, 173, 186, 199,
    212, 226, 240, 255};

  initial
  begin
    req = '0;
    pwm = 8'h00;
  end

  // Released address shows its inverse, not a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
  endtask : rd

  // Brightness written once at the next falling edge; a soft breath ramp calls it every cycle
  task automatic put(input logic [7:0] v);
    @(negedge core_clk);
    pwm <= v;
  endtask : put
endmodule : lmac_host

// *** bench/tb.sv ***
// Testbench: registers, pixel path, audio frames, blink, breathing
`timescale 1ns/1ps
module tb import lmac_pkg::*;;
  logic          core_clk = 1'b0;
  logic          rstn;
  lmac_reg_req_t req;
  logic [7:0]    reg_rdata, pix_pwm, pix_duty, pv, lvl;
  logic          blk;
  lmac_disp_t    disp;
  logic          agc_en, agc_f, g_act, strb;
  logic [2:0]    g_code;
  logic [7:0]    mdl [256];
  int            n_errors = 0, checked = 0, seed = 48775, n, k;

  always #5 core_clk = ~core_clk;

  lmac_core #(.BREATH_CYC(256), .SAMPLE_CYC(8), .FRAME_CYC(20),
    .BLINK_CYC(10), .SCAN_CYC(4)) DUT (
    .core_clk      (core_clk),
    .rstn          (rstn),
    .reg_req       (req),
    .reg_rdata     (reg_rdata),
    .audio_level   (lvl),
    .pix_pwm       (pix_pwm),
    .pix_blink     (blk),
    .pix_duty      (pix_duty),
    .disp          (disp),
    .agc_enable    (agc_en),
    .agc_fast      (agc_f),
    .gain_code     (g_code),
    .gain_active   (g_act),
    .sample_strobe (strb)
  );
  lmac_host host (.core_clk(core_clk), .req(req), .pwm(pix_pwm));

  // ------------------------------------------------------------
  // Model and helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h0A: msk = 8'h01;
      8'h0B: msk = 8'h1F;
      8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h08, 8'h09,
      8'h0C: msk = 8'hFF;
      default: msk = 8'h00;
    endcase
  endfunction : msk

  // Gain steps of 3 dB as x/16 multipliers, saturating
  function automatic logic [7:0] gain(input int l, input int c);
    int m [8] = '{16, 23, 32, 45, 64, 91, 128, 181};
    gain = (l * m[c] / 16 > 255) ? 8'hFF : 8'(l * m[c] / 16);
  endfunction : gain

  task automatic chk(input string nm, input logic [15:0] s, e);
    checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    mdl[a] = d & msk(a);
  endtask : w

  task automatic r(input logic [7:0] a);
    host.rd(a);
    chk("rdata", {8'h00, reg_rdata}, {8'h00, mdl[a]});
  endtask : r

  // Cycles up to the next sample pulse, bounded
  task automatic gap(output int c);
    c = 0;
    do
    begin
      @(negedge core_clk);
      c++;
    end
    while (strb !== 1'b1 && c < 5000);
  endtask : gap

  task automatic conclude;
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    #(40000 * 10);
    n_errors++;
    conclude();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    lvl  = 8'h00;
    blk  = 1'b0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    r(8'h0A);
    r(8'h0B);
    r(8'h0C);
    r(8'hFE);
    host.put(8'h80);
    host.put(8'h80);
    chk("blank", {15'h0, disp.blank}, 16'h1);
    chk("duty", {8'h0, pix_duty}, 16'h0);
    w(8'h0A, 8'hFF);
    r(8'h0A);
    w(8'h0B, 8'hFF);
    r(8'h0B);
    w(8'h0B, 8'h00);
    w(8'h0C, 8'hA5);
    for (int i = 0; i < 64; i++)
    begin
      lvl = (i < 32) ? host.gam[i] : 8'($random(seed));
      host.put(lvl);
      if (i > 0) chk("duty", {8'h0, pix_duty}, {8'h0, pv});
      pv = lvl;
    end
    w(8'h0A, 8'h00);
    repeat (2) @(negedge core_clk);
    chk("duty", {8'h0, pix_duty}, 16'h0);
    r(8'h0C);
    w(8'h0A, 8'h01);
    for (int g = 0; g < 8; g++)
    begin
      w(8'h0B, (8'($random(seed)) & 8'h18) | 8'(g));
      chk("agc", {11'h0, agc_f, agc_en, g_code}, {8'h0, mdl[8'h0B]});
    end
    w(8'h01, 8'h05);
    w(8'h00, 8'h00);
    repeat (12) @(negedge core_clk);
    chk("frame", {13'h0, disp.frame}, 16'h5);
    mdl[8'h07] = 8'h05;
    r(8'h07);
    w(8'h00, 8'h10);
    w(8'h0C, 8'h02);
    for (int g = 0; g < 8; g++)
    begin
      lvl = 8'($random(seed));
      w(8'h0B, 8'(g));
      gap(n);
      gap(n);
      chk("gap", 16'(n), 16'h10);
      repeat (3) @(negedge core_clk);
      chk("frame", {13'h0, disp.frame}, {8'h0, gain(lvl, g) >> 5});
      chk("gact", {15'h0, g_act}, 16'h1);
    end
    w(8'h0C, 8'h00);
    gap(n);
    gap(n);
    chk("gap", 16'(n), 16'd2048);
    w(8'h00, 8'h00);
    w(8'h05, 8'h08);
    blk = 1'b1;
    host.put(8'h80);
    for (int p = 0; p < 3; p++)
    begin
      n = 0;
      while (disp.blink_phase === 1'(p % 2) && n < 100)
      begin
        @(negedge core_clk);
        n++;
      end
      n = 0;
      while (disp.blink_phase === 1'(~p % 2) && n < 100)
      begin
        if (p % 2 == 1 && n > 2 && n < 8)
          chk("blink", {8'h0, pix_duty}, 16'h0);
        @(negedge core_clk);
        n++;
      end
      if (p > 0) chk("half", 16'(n), 16'd10);
    end
    w(8'h05, 8'h00);
    blk = 1'b0;
    w(8'h09, 8'h01);
    k = 0;
    repeat (1500)
    begin
      @(negedge core_clk);
      k += (disp.breath !== 8'hFF);
    end
    chk("still", 16'(k), 16'h0);
    w(8'h09, 8'h11);
    n = 0;
    while (disp.breath !== 8'h00 && n < 3000)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("fade", 16'(n < 3000), 16'h1);
    n = 0;
    while (disp.breath === 8'h00 && n < 5000)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("dark", 16'(n >= 510 && n <= 514), 16'h1);
    // Auto play: three frames from frame 2, one loop, 20 cycle hold
    w(8'h09, 8'h00);
    w(8'h02, 8'h13);
    w(8'h03, 8'h01);
    w(8'h00, 8'h0A);
    repeat (8) @(negedge core_clk);
    chk("auto", {13'h0, disp.frame}, 16'h2);
    repeat (100) @(negedge core_clk);
    chk("auto", {13'h0, disp.frame}, 16'h4);
    mdl[8'h07] = 8'h04;
    r(8'h07);
    // Audio sync scales duty by the gained level
    w(8'h06, 8'h01);
    for (int g = 0; g < 8; g++)
    begin
      lvl = 8'($random(seed));
      pv = 8'($random(seed));
      w(8'h0B, 8'(g));
      host.put(pv);
      repeat (2) @(negedge core_clk);
      chk("sync", {8'h0, pix_duty},
          16'((int'(pv) * (int'(gain(lvl, g)) + 1)) >> 8));
    end
    conclude();
  end
endmodule : tb
